// ---- dscg_pkg.sv ----
package dscg_pkg;

   // Register byte offsets
   localparam logic [11:0] DSCG_OFS_RUN_GATE   = 12'h104;
   localparam logic [11:0] DSCG_OFS_SLEEP_GATE = 12'h114;
   localparam logic [11:0] DSCG_OFS_DEEP_GATE  = 12'h128;
   localparam logic [11:0] DSCG_OFS_RUN_CFG    = 12'h060;
   localparam logic [11:0] DSCG_OFS_IRQ_STAT   = 12'h180;
   localparam logic [11:0] DSCG_OFS_IRQ_EN     = 12'h184;
   localparam logic [11:0] DSCG_OFS_IRQ_CLR    = 12'h188;

   // Field positions and unit counts
   localparam int DSCG_BIT_PHY   = 30;
   localparam int DSCG_BIT_MAC   = 28;
   localparam int DSCG_BIT_ACG   = 0;
   localparam int DSCG_NUM_PORTS = 8;
   localparam int DSCG_NUM_UNITS = 10;

   // Writable bits of a gate register
   localparam logic [31:0] DSCG_GATE_MASK = 32'h500000ff;
   localparam logic [31:0] DSCG_GATE_RST  = 32'h00000000;
   localparam logic [31:0] DSCG_CFG_RST   = 32'h00000000;

   // Interrupt status bits
   localparam int DSCG_IRQ_FAULT = 0;
   localparam int DSCG_IRQ_MODE  = 1;
   localparam int DSCG_IRQ_W     = 2;

   typedef enum logic [2:0] {
      DSCG_PWR_RUN   = 3'h1,
      DSCG_PWR_SLEEP = 3'h2,
      DSCG_PWR_DEEP  = 3'h4
   } dscg_pwr_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } dscg_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] dat;
   } dscg_wb_rsp_t;

   // One unit-side access request, as seen by the fault check
   typedef struct packed {
      logic                      valid;
      logic [DSCG_NUM_UNITS-1:0] unit_sel;
   } dscg_unit_acc_t;

endpackage

// ---- dscg_top.sv ----
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module dscg_top (
   // System clock and reset
   input  wire logic                               clk_i,
   input  wire logic                               rst_i,
   // Wishbone slave
   input  wire dscg_pkg::dscg_wb_req_t             wb_req_i,
   output dscg_pkg::dscg_wb_rsp_t                  wb_rsp_o,
   // Power state from the core
   input  wire logic                               sleep_i,
   input  wire logic                               deep_sleep_i,
   // Unit access watch for fault reporting
   input  wire dscg_pkg::dscg_unit_acc_t           unit_acc_i,
   output logic                                    unit_fault_o,
   // Gated unit clocks and enables, bit 9 PHY, bit 8 MAC, 7..0 ports H..A
   output logic [dscg_pkg::DSCG_NUM_UNITS-1:0]     unit_clk_o,
   output logic [dscg_pkg::DSCG_NUM_UNITS-1:0]     unit_en_o,
   // Interrupt
   output logic                                    irq_o
);

   localparam int NU = dscg_pkg::DSCG_NUM_UNITS;

   logic [31:0]                 run_gate_q;
   logic [31:0]                 sleep_gate_q;
   logic [31:0]                 deep_gate_q;
   logic [31:0]                 run_cfg_q;
   logic [dscg_pkg::DSCG_IRQ_W-1:0] irq_stat_q;
   logic [dscg_pkg::DSCG_IRQ_W-1:0] irq_en_q;
   logic                        ack_q;
   logic                        err_q;
   logic [31:0]                 rdat_q;
   logic                        fault_q;
   dscg_pkg::dscg_pwr_t         pwr_q;
   dscg_pkg::dscg_pwr_t         pwr_d;
   logic [31:0]                 active_gate;
   logic [NU-1:0]               unit_on;
   logic [NU-1:0]               en_q;
   logic                        req;
   logic                        wr;
   logic                        hit;
   logic [31:0]                 wmask;
   logic [31:0]                 rd_mux;
   logic                        fault_ev;
   logic [dscg_pkg::DSCG_IRQ_W-1:0] ev;
   logic [dscg_pkg::DSCG_IRQ_W-1:0] clr;

   assign req   = wb_req_i.cyc && wb_req_i.stb && !ack_q && !err_q;
   assign wr    = req && wb_req_i.we;
   assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                   {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

   // Register writes, masked to the writable gate bits; the run config takes only its ACG bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_gate_q   <= dscg_pkg::DSCG_GATE_RST;
         sleep_gate_q <= dscg_pkg::DSCG_GATE_RST;
         deep_gate_q  <= dscg_pkg::DSCG_GATE_RST;
         run_cfg_q    <= dscg_pkg::DSCG_CFG_RST;
      end else if (wr) begin
         case (wb_req_i.adr)
            dscg_pkg::DSCG_OFS_RUN_GATE:
               run_gate_q <= (run_gate_q & ~(wmask & dscg_pkg::DSCG_GATE_MASK))
                           | (wb_req_i.dat & wmask & dscg_pkg::DSCG_GATE_MASK);
            dscg_pkg::DSCG_OFS_SLEEP_GATE:
               sleep_gate_q <= (sleep_gate_q & ~(wmask & dscg_pkg::DSCG_GATE_MASK))
                             | (wb_req_i.dat & wmask & dscg_pkg::DSCG_GATE_MASK);
            dscg_pkg::DSCG_OFS_DEEP_GATE:
               deep_gate_q <= (deep_gate_q & ~(wmask & dscg_pkg::DSCG_GATE_MASK))
                            | (wb_req_i.dat & wmask & dscg_pkg::DSCG_GATE_MASK);
            dscg_pkg::DSCG_OFS_RUN_CFG:
               if (wb_req_i.sel[0]) begin
                  run_cfg_q[dscg_pkg::DSCG_BIT_ACG] <= wb_req_i.dat[dscg_pkg::DSCG_BIT_ACG];
               end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      hit = 1'b1;
      case (wb_req_i.adr)
         dscg_pkg::DSCG_OFS_RUN_GATE:   rd_mux = run_gate_q;
         dscg_pkg::DSCG_OFS_SLEEP_GATE: rd_mux = sleep_gate_q;
         dscg_pkg::DSCG_OFS_DEEP_GATE:  rd_mux = deep_gate_q;
         dscg_pkg::DSCG_OFS_RUN_CFG:    rd_mux = run_cfg_q;
         dscg_pkg::DSCG_OFS_IRQ_STAT:   rd_mux = {30'h0, irq_stat_q};
         dscg_pkg::DSCG_OFS_IRQ_EN:     rd_mux = {30'h0, irq_en_q};
         dscg_pkg::DSCG_OFS_IRQ_CLR:    rd_mux = 32'h00000000;
         default: begin
            rd_mux = 32'h00000000;
            hit    = 1'b0;
         end
      endcase
   end

   // One-cycle answer; unmapped address ends with err
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         err_q  <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q  <= req && hit;
         err_q  <= req && !hit;
         rdat_q <= (req && hit && !wb_req_i.we) ? rd_mux : 32'h00000000;
      end
   end

   assign wb_rsp_o.ack = ack_q;
   assign wb_rsp_o.err = err_q;
   assign wb_rsp_o.dat = rdat_q;

   // Power state tracking; deep sleep wins over sleep
   always_comb begin
      if (deep_sleep_i) begin
         pwr_d = dscg_pkg::DSCG_PWR_DEEP;
      end else if (sleep_i) begin
         pwr_d = dscg_pkg::DSCG_PWR_SLEEP;
      end else begin
         pwr_d = dscg_pkg::DSCG_PWR_RUN;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwr_q <= dscg_pkg::DSCG_PWR_RUN;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   // Gate set selection by power state
   always_comb begin
      case (pwr_q)
         dscg_pkg::DSCG_PWR_RUN:   active_gate = run_gate_q;
         dscg_pkg::DSCG_PWR_SLEEP: active_gate =
            run_cfg_q[dscg_pkg::DSCG_BIT_ACG] ? sleep_gate_q : run_gate_q;
         dscg_pkg::DSCG_PWR_DEEP:  active_gate =
            run_cfg_q[dscg_pkg::DSCG_BIT_ACG] ? deep_gate_q : run_gate_q;
         default:                  active_gate = run_gate_q;
      endcase
   end

   assign unit_on = {active_gate[dscg_pkg::DSCG_BIT_PHY],
                     active_gate[dscg_pkg::DSCG_BIT_MAC],
                     active_gate[dscg_pkg::DSCG_NUM_PORTS-1:0]};

   // Clock gate per unit: enable latched while clock is low
   genvar g;
   generate
      for (g = 0; g < NU; g++) begin : g_cg
         logic lat_en;
         always_latch begin
            if (!clk_i) begin
               lat_en = en_q[g];
            end
         end
         assign unit_clk_o[g] = clk_i & lat_en;
      end
   endgenerate

   // Registered enables keep the latch input free of decode glitches
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q <= '0;
      end else begin
         en_q <= unit_on;
      end
   end

   assign unit_en_o = en_q;

   // Fault on access to an unclocked unit
   assign fault_ev = unit_acc_i.valid && |(unit_acc_i.unit_sel & ~en_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= fault_ev;
      end
   end

   assign unit_fault_o = fault_q;

   // Sticky events; a new event wins over a same-cycle clear
   assign ev[dscg_pkg::DSCG_IRQ_FAULT] = fault_ev;
   assign ev[dscg_pkg::DSCG_IRQ_MODE]  = (pwr_d != pwr_q);
   assign clr = (wr && wb_req_i.adr == dscg_pkg::DSCG_OFS_IRQ_CLR && wb_req_i.sel[0])
              ? wb_req_i.dat[dscg_pkg::DSCG_IRQ_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~clr) | ev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_q <= '0;
      end else if (wr && wb_req_i.adr == dscg_pkg::DSCG_OFS_IRQ_EN && wb_req_i.sel[0]) begin
         irq_en_q <= wb_req_i.dat[dscg_pkg::DSCG_IRQ_W-1:0];
      end
   end

   assign irq_o = |(irq_stat_q & irq_en_q);

endmodule

// ---- dscg_asserts.sv ----
`timescale 1ns/1ps
module dscg_asserts (
   // Clock and reset
   input wire logic                     clk_i,
   input wire logic                     rst_i,
   // Watched ports
   input wire dscg_pkg::dscg_wb_req_t   wb_req_i,
   input wire dscg_pkg::dscg_wb_rsp_t   wb_rsp_o,
   input wire logic                     sleep_i,
   input wire logic                     deep_sleep_i,
   input wire dscg_pkg::dscg_unit_acc_t unit_acc_i,
   input wire logic                     unit_fault_o,
   input wire logic [9:0]               unit_clk_o,
   input wire logic [9:0]               unit_en_o,
   input wire logic                     irq_o
);
   wire       req = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && !wb_rsp_o.err;
   wire [1:0] pw  = {sleep_i, deep_sleep_i};
   wire [9:0] gv  = {wb_req_i.dat[30], wb_req_i.dat[28], wb_req_i.dat[7:0]};
   wire       bad = unit_acc_i.valid && |(unit_acc_i.unit_sel & ~unit_en_o);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ANSWER: assert property (req |=> wb_rsp_o.ack || wb_rsp_o.err)
      else $error("no answer");
   AST_ACK_ONE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack too long");
   AST_RUN_EN: assert property (req && wb_req_i.we && pw == 2'b00 &&
      wb_req_i.adr == dscg_pkg::DSCG_OFS_RUN_GATE && wb_req_i.sel == 4'hf
      |-> ##3 unit_en_o == $past(gv, 3)) else $error("enable mismatch");
   AST_HOLD: assert property ($stable(pw) && $past(pw) == $past(pw, 2) &&
      !wb_rsp_o.ack |=> $stable(unit_en_o)) else $error("enable moved");
   AST_FAULT: assert property (bad |=> unit_fault_o)
      else $error("fault missing");
   AST_NO_FAULT: assert property (!bad |=> !unit_fault_o)
      else $error("fault spurious");
   AST_GATE: assert property (@(negedge clk_i) unit_clk_o == $past(unit_en_o))
      else $error("gated clock wrong");
   AST_RSVD: assert property (wb_rsp_o.ack && !wb_req_i.we &&
      wb_req_i.adr == dscg_pkg::DSCG_OFS_DEEP_GATE
      |-> (wb_rsp_o.dat & ~dscg_pkg::DSCG_GATE_MASK) == '0) else $error("reserved set");
   AST_RST: assert property (disable iff (1'b0) rst_i |=> unit_en_o == '0 && !irq_o)
      else $error("reset state wrong");
endmodule
bind dscg_top dscg_asserts dscg_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
   .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .sleep_i(sleep_i),
   .deep_sleep_i(deep_sleep_i), .unit_acc_i(unit_acc_i), .unit_fault_o(unit_fault_o),
   .unit_clk_o(unit_clk_o), .unit_en_o(unit_en_o), .irq_o(irq_o));

// ---- tb_dscg_top.sv ----
`timescale 1ns/1ps
module tb_dscg_top;
   logic                     clk_i = 1'b0;
   logic                     rst_i = 1'b1;
   dscg_pkg::dscg_wb_req_t   req   = '0;
   dscg_pkg::dscg_wb_rsp_t   rsp;
   logic                     slp   = 1'b0;
   logic                     dsl   = 1'b0;
   dscg_pkg::dscg_unit_acc_t acc   = '0;
   logic                     fault;
   logic [9:0]               uclk;
   logic [9:0]               en;
   logic                     irq;
   int                       errors = 0;
   int                       comparisons = 0;
   int                       seed = 32'h40a2;
   logic [32:0]              expq[$];
   logic [31:0]              d;
   always #4 clk_i = ~clk_i;
   dscg_top dscg_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
      .sleep_i(slp), .deep_sleep_i(dsl), .unit_acc_i(acc), .unit_fault_o(fault),
      .unit_clk_o(uclk), .unit_en_o(en), .irq_o(irq));
   task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Reads and refused cycles leave a note for the watcher
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v,
                      input logic [32:0] e);
      int n = 0;
      if (!w || e[32])
         expq.push_back(e);
      req <= '{1'b1, 1'b1, w, 4'hf, a, v};
      do begin
         @(posedge clk_i);
         n++;
      end while (!(rsp.ack || rsp.err) && n < 20);
      if (n >= 20)
         errors++;
      req <= '0;
      @(posedge clk_i);
   endtask
   always @(posedge clk_i) begin
      if ((rsp.ack || rsp.err) && (!req.we || rsp.err) && expq.size() > 0)
         chk("bus", {rsp.err, rsp.dat}, expq.pop_front());
   end
   task automatic en_is(input logic [9:0] e);
      repeat (2) @(posedge clk_i);
      #1;
      chk("enables", {23'h0, en}, {23'h0, e});
      @(posedge clk_i);
   endtask
   task automatic poke(input logic [9:0] s, input logic e);
      acc <= '{1'b1, s};
      @(posedge clk_i);
      acc <= '0;
      #1;
      chk("fault", {32'h0, fault}, {32'h0, e});
      @(posedge clk_i);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, dscg_pkg::DSCG_OFS_DEEP_GATE, 32'h0, 33'h0);
      bus(1'b0, dscg_pkg::DSCG_OFS_IRQ_STAT, 32'h0, 33'h0);
      $display("t1 done");
      repeat (4) begin
         d = $random(seed);
         bus(1'b1, dscg_pkg::DSCG_OFS_DEEP_GATE, d, 33'h0);
         bus(1'b0, dscg_pkg::DSCG_OFS_DEEP_GATE, 32'h0, {1'b0, d & 32'h500000ff});
      end
      bus(1'b0, 12'h12c, 32'h0, 33'h100000000);
      $display("t2 done");
      bus(1'b1, dscg_pkg::DSCG_OFS_RUN_GATE, 32'h50000001, 33'h0);
      en_is(10'h301);
      bus(1'b1, dscg_pkg::DSCG_OFS_IRQ_EN, 32'h0, 33'h0);
      poke(10'h002, 1'b1);
      repeat (6) begin
         d = $random(seed);
         poke(d[9:0], |(d[9:0] & ~10'h301));
      end
      chk("irq masked", {32'h0, irq}, 33'h0);
      bus(1'b1, dscg_pkg::DSCG_OFS_IRQ_EN, 32'h1, 33'h0);
      chk("irq", {32'h0, irq}, 33'h1);
      bus(1'b0, dscg_pkg::DSCG_OFS_IRQ_STAT, 32'h0, 33'h1);
      bus(1'b1, dscg_pkg::DSCG_OFS_IRQ_CLR, 32'h1, 33'h0);
      chk("irq cleared", {32'h0, irq}, 33'h0);
      $display("t3 done");
      bus(1'b1, dscg_pkg::DSCG_OFS_DEEP_GATE, 32'h80, 33'h0);
      bus(1'b1, dscg_pkg::DSCG_OFS_SLEEP_GATE, 32'h10000000, 33'h0);
      bus(1'b1, dscg_pkg::DSCG_OFS_RUN_CFG, 32'h1, 33'h0);
      dsl <= 1'b1;
      en_is(10'h080);
      dsl <= 1'b0;
      slp <= 1'b1;
      en_is(10'h100);
      bus(1'b1, dscg_pkg::DSCG_OFS_RUN_CFG, 32'h0, 33'h0);
      en_is(10'h301);
      $display("t4 done");
      give_verdict();
   end
   initial begin
      #20000;
      errors++;
      give_verdict();
   end
endmodule
